// ==== hdl/idfw_words.sv ====
`timescale 1ns/1ps
`include "idfw_defs.svh"
module idfw_words import idfw_pkg::*; (
  input  wire logic      I_MCLK,     // 200 MHz clock
  input  wire logic      I_SYS_RST,  // sync reset, high
  input  wire idfw_cfg_s I_CFG,      // card configuration
  input  wire logic      I_RD,       // read strobe
  input  wire idfw_idx_t I_IDX,      // word index
  output logic           O_VLD,      // data valid pulse
  output idfw_word_t     O_DATA,     // identify word
  output logic           O_PIO_VLD   // word 53 bit 1
);

  // ****************************************
  // word assembly
  // ****************************************
  function automatic idfw_word_t word_of(input idfw_cfg_s c, input idfw_idx_t i);
    idfw_word_t w;
    logic       adv;
    w   = 16'h0000;
    adv = c.pio_m3 | c.pio_m4;
    unique case (i)
      `IDFW_W_PIO_NOFC:  if (adv) w = `IDFW_PIO_NOFC_NS;
      `IDFW_W_PIO_IORDY: if (adv) begin
        w = c.pio_m4 ? `IDFW_PIO_MODE4_NS : `IDFW_PIO_MODE3_NS;
      end
      `IDFW_W_SUP0: begin
        w = `IDFW_SUP0_FIXED;
        w[`IDFW_BIT_SEC] = c.sec_sup;
        w[`IDFW_BIT_WC]  = c.wc_sup;
        w[`IDFW_BIT_LA]  = c.la_sup;
      end
      `IDFW_W_SUP1: begin
        w = `IDFW_SUP1_FIXED;
        w[`IDFW_BIT_APM] = c.apm_sup;
      end
      `IDFW_W_SUP2: w = `IDFW_SUP2_FIXED;
      `IDFW_W_EN0: begin
        w = `IDFW_SUP0_FIXED;
        w[`IDFW_BIT_SEC] = c.sec_en;
        w[`IDFW_BIT_WC]  = c.wc_en;
        w[`IDFW_BIT_LA]  = c.la_en;
      end
      `IDFW_W_EN1: begin
        w[`IDFW_BIT_FLASH] = 1'b1;
        w[`IDFW_BIT_APM]   = c.apm_en;
      end
      `IDFW_W_EN2: w = `IDFW_EN2_FIXED;
      `IDFW_W_UDMA: if (c.udma_any) begin
        for (int m = 0; m < 5; m++) begin
          w[m] = (3'(m) <= c.udma_max);
        end
        // selection shown only when multiword dma is not chosen
        if (c.udma_sel && !c.mdma_sel && c.udma_mode <= 3'h4) begin
          w[`IDFW_UDMA_SEL_LSB + int'(c.udma_mode)] = 1'b1;
        end
      end
      `IDFW_W_ERASE:  w = {8'h00, c.erase_t};
      `IDFW_W_EERASE: w = {8'h00, c.eerase_t};
      `IDFW_W_APM:    w = {8'h00, c.apm_lvl};
      default: w = 16'h0000;
    endcase
    return w;
  endfunction

  // ****************************************
  // state
  // ****************************************
  idfw_state_s st_q, st_d;

  // one cycle read latency
  always_comb begin
    st_d      = st_q;
    st_d.vld  = I_RD;
    if (I_RD) begin
      st_d.data = word_of(I_CFG, I_IDX);
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign O_VLD     = st_q.vld;
  assign O_DATA    = st_q.data;
  assign O_PIO_VLD = I_CFG.pio_m3 | I_CFG.pio_m4;

  // ****************************************
  // checks
  // ****************************************
  // a read taken at one edge for one word index
  sequence rd_word(idfw_idx_t k);
    I_RD && I_IDX == k;
  endsequence

  // one named read per word except 89 and 90, so the properties below read as steps
  sequence rd_nofc;
    rd_word(`IDFW_W_PIO_NOFC);
  endsequence

  sequence rd_iordy;
    rd_word(`IDFW_W_PIO_IORDY);
  endsequence

  sequence rd_sup0;
    rd_word(`IDFW_W_SUP0);
  endsequence

  sequence rd_sup1;
    rd_word(`IDFW_W_SUP1);
  endsequence

  sequence rd_sup2;
    rd_word(`IDFW_W_SUP2);
  endsequence

  sequence rd_en0;
    rd_word(`IDFW_W_EN0);
  endsequence

  sequence rd_en1;
    rd_word(`IDFW_W_EN1);
  endsequence

  sequence rd_en2;
    rd_word(`IDFW_W_EN2);
  endsequence

  sequence rd_udma;
    rd_word(`IDFW_W_UDMA);
  endsequence

  sequence rd_apm;
    rd_word(`IDFW_W_APM);
  endsequence

  // ****************************************
  // handshake checks
  // ****************************************

  // every taken read answers on the next edge
  valid_lat_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    I_RD |=> O_VLD)
    else $error("read not answered in one cycle");

  // no answer without a request, so the strobe is a clean pulse
  vld_pulse_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    !I_RD |=> !O_VLD)
    else $error("answer strobe without read");

  // the last word stays put between reads; host may sample late
  data_hold_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    !I_RD |=> $stable(O_DATA))
    else $error("read word changed without read");

  // reset leaves the read side quiet and zero
  reset_quiet_a: assert property (@(posedge I_MCLK)
    I_SYS_RST |=> !O_VLD && O_DATA == 16'h0000)
    else $error("read side not cleared by reset");

  // indices outside the run read as zero
  unlisted_zero_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    I_RD && !(I_IDX inside {`IDFW_W_PIO_NOFC, `IDFW_W_PIO_IORDY,
                            [`IDFW_W_SUP0 : `IDFW_W_APM]})
    |=> O_DATA == 16'h0000)
    else $error("unlisted word not zero");

  // ****************************************
  // pio timing words
  // ****************************************

  // word 67 filled once an advanced pio mode exists
  nofc_val_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    rd_nofc ##0 O_PIO_VLD
    |=> O_DATA == `IDFW_PIO_NOFC_NS)
    else $error("word 67 time wrong");

  // without advanced modes word 67 reads zero
  nofc_zero_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    rd_nofc ##0 !O_PIO_VLD
    |=> O_DATA == 16'h0000)
    else $error("word 67 not zero");

  // without advanced modes word 68 reads zero
  iordy_zero_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    rd_iordy ##0 !O_PIO_VLD
    |=> O_DATA == 16'h0000)
    else $error("word 68 not zero");

  // fastest mode wins when both are supported
  iordy_fast_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    rd_iordy ##0 I_CFG.pio_m4
    |=> O_DATA == `IDFW_PIO_MODE4_NS)
    else $error("word 68 not mode 4 time");

  // mode 3 only gives the slower time
  iordy_m3_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    rd_iordy ##0 (I_CFG.pio_m3 && !I_CFG.pio_m4)
    |=> O_DATA == `IDFW_PIO_MODE3_NS)
    else $error("word 68 not mode 3 time");

  // reads of 67 then 68 two edges apart, settings unchanged
  pio_order_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    rd_nofc ##2 (I_RD && I_IDX == `IDFW_W_PIO_IORDY && $stable(I_CFG))
    |=> O_DATA <= $past(O_DATA, 2))
    else $error("word 67 below word 68");

  // the validity flag promises a filled word 67
  pio_flag_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    rd_nofc ##0 O_PIO_VLD
    |=> O_DATA != 16'h0000)
    else $error("flagged word 67 empty");

  // ****************************************
  // supported feature words
  // ****************************************

  // fixed ones and zeros of word 82; obsolete bits kept low
  sup_fixed_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    rd_sup0 |=> (O_DATA & 16'hf79d) == 16'h7008)
    else $error("word 82 wrong");

  // unsupported sets of word 82 stay low
  sup0_zero_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    rd_sup0 |=> (O_DATA & 16'h0795) == 16'h0000)
    else $error("word 82 unsupported bit set");

  // configuration flags of word 82
  sup0_cfg_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    rd_sup0 |=> O_DATA[1] == $past(I_CFG.sec_sup) && O_DATA[5] == $past(I_CFG.wc_sup)
                && O_DATA[6] == $past(I_CFG.la_sup))
    else $error("word 82 config bit wrong");

  // validity marker of word 83
  sup_marker_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    rd_sup1 |=> O_DATA[15:14] == 2'b01)
    else $error("word 83 marker wrong");

  // fixed bits of word 83
  sup1_fixed_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    rd_sup1 |=> O_DATA[1:0] == 2'b00 && O_DATA[2] && !O_DATA[4])
    else $error("word 83 fixed bit wrong");

  // apm support flag of word 83
  sup1_apm_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    rd_sup1 |=> O_DATA[3] == $past(I_CFG.apm_sup))
    else $error("word 83 apm bit wrong");

  // reserved middle of word 83 stays low
  sup1_rsvd_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    rd_sup1 |=> O_DATA[13:5] == 9'h000)
    else $error("word 83 reserved bit set");

  // word 84 carries only its marker
  sup2_marker_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    rd_sup2 |=> O_DATA == 16'h4000)
    else $error("word 84 wrong");

  // ****************************************
  // enabled feature words
  // ****************************************

  // unsupported sets of word 85 stay low
  en0_zero_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    rd_en0 |=> (O_DATA & 16'h0795) == 16'h0000)
    else $error("word 85 unsupported bit set");

  // always-on sets of word 85
  en0_fixed_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    rd_en0 |=> (O_DATA & 16'h7008) == 16'h7008)
    else $error("word 85 fixed bit low");

  // current settings of word 85
  en0_cfg_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    rd_en0 |=> O_DATA[1] == $past(I_CFG.sec_en) && O_DATA[5] == $past(I_CFG.wc_en)
               && O_DATA[6] == $past(I_CFG.la_en))
    else $error("word 85 setting bit wrong");

  // fixed bits of word 86
  en1_fixed_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    rd_en1 |=> O_DATA[1:0] == 2'b00 && O_DATA[2] && !O_DATA[4])
    else $error("word 86 fixed bit wrong");

  // apm enable flag of word 86
  en1_apm_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    rd_en1 |=> O_DATA[3] == $past(I_CFG.apm_en))
    else $error("word 86 apm bit wrong");

  // upper word 86 reserved
  en1_rsvd_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    rd_en1 |=> O_DATA[15:5] == 11'h000)
    else $error("word 86 reserved bit set");

  // word 87 carries only its marker
  en_marker_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    rd_en2 |=> O_DATA == 16'h4000)
    else $error("word 87 wrong");

  // ****************************************
  // dma, erase and power words
  // ****************************************

  // at most one ultra dma mode shown as selected
  udma_hot_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    rd_udma |=> $onehot0(O_DATA[12:8]))
    else $error("udma select not one-hot");

  // a multiword choice hides every ultra dma selection
  udma_mdma_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    rd_udma ##0 I_CFG.mdma_sel
    |=> O_DATA[12:8] == 5'h00)
    else $error("udma selected beside multiword");

  // support bits fill from mode 0 upward
  udma_cum_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    rd_udma |=> ((O_DATA[4:0] + 5'h01) & O_DATA[4:0]) == 5'h00)
    else $error("udma support not cumulative");

  // reserved fields of word 88
  udma_rsvd_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    rd_udma |=> O_DATA[7:5] == 3'h0 && O_DATA[15:13] == 3'h0)
    else $error("word 88 reserved bit set");

  // any ultra dma support shows at least mode 0
  udma_given_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    rd_udma ##0 I_CFG.udma_any
    |=> O_DATA[0])
    else $error("word 88 missing");

  // erase time code passed through unchanged
  erase_code_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    rd_word(`IDFW_W_ERASE) |=> O_DATA == {8'h00, $past(I_CFG.erase_t)})
    else $error("word 89 wrong");

  // enhanced erase time code passed through unchanged
  eerase_code_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    rd_word(`IDFW_W_EERASE) |=> O_DATA == {8'h00, $past(I_CFG.eerase_t)})
    else $error("word 90 wrong");

  // level from the settings at the taking edge
  apm_level_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    rd_apm |=> O_DATA == {8'h00, $past(I_CFG.apm_lvl)})
    else $error("apm level wrong");
endmodule

// ==== common/idfw_defs.svh ====
`ifndef IDFW_DEFS_SVH
`define IDFW_DEFS_SVH
`define IDFW_W_PIO_NOFC   7'h43
`define IDFW_W_PIO_IORDY  7'h44
`define IDFW_W_SUP0       7'h52
`define IDFW_W_SUP1       7'h53
`define IDFW_W_SUP2       7'h54
`define IDFW_W_EN0        7'h55
`define IDFW_W_EN1        7'h56
`define IDFW_W_EN2        7'h57
`define IDFW_W_UDMA       7'h58
`define IDFW_W_ERASE      7'h59
`define IDFW_W_EERASE     7'h5a
`define IDFW_W_APM        7'h5b
`define IDFW_SUP0_FIXED   16'h7008
`define IDFW_SUP1_FIXED   16'h4004
`define IDFW_SUP2_FIXED   16'h4000
`define IDFW_EN2_FIXED    16'h4000
`define IDFW_BIT_SEC      1
`define IDFW_BIT_WC       5
`define IDFW_BIT_LA       6
`define IDFW_BIT_FLASH    2
`define IDFW_BIT_APM      3
`define IDFW_UDMA_SEL_LSB 8
`define IDFW_PIO_MODE3_NS 16'h00b4
`define IDFW_PIO_MODE4_NS 16'h0078
`define IDFW_PIO_NOFC_NS  16'h00b4
`endif

// ==== common/idfw_pkg.sv ====
package idfw_pkg;
  typedef logic [15:0] idfw_word_t;
  typedef logic [6:0]  idfw_idx_t;

  // configuration and current settings of the card
  typedef struct packed {
    logic       pio_m3;    // pio mode 3 supported
    logic       pio_m4;    // pio mode 4 supported
    logic       sec_sup;   // security supported
    logic       wc_sup;    // write cache supported
    logic       la_sup;    // look-ahead supported
    logic       apm_sup;   // advanced power management supported
    logic       sec_en;    // security enabled by password
    logic       wc_en;     // write cache enabled
    logic       la_en;     // look-ahead enabled
    logic       apm_en;    // apm enabled by set features
    logic [2:0] udma_max;  // highest udma mode supported
    logic       udma_any;  // any udma supported
    logic       udma_sel;  // udma mode selected
    logic [2:0] udma_mode; // selected udma mode
    logic       mdma_sel;  // multiword dma selected
    logic [7:0] erase_t;   // security erase time code
    logic [7:0] eerase_t;  // enhanced erase time code
    logic [7:0] apm_lvl;   // current apm level
  } idfw_cfg_s;

  typedef struct packed {
    logic       vld;
    idfw_word_t data;
  } idfw_state_s;
endpackage

// ==== sim/idfw_host.sv ====
`timescale 1ns/1ps
// ****************
// host read model
// ****************
module idfw_host import idfw_pkg::*; (
  input  wire logic       i_clk,  // card clock
  input  wire logic       i_vld,  // answer strobe
  input  wire idfw_word_t i_data, // answered word
  output logic            o_rd,   // read strobe
  output idfw_idx_t       o_idx   // word index
);
  initial begin
    o_rd = 1'b0;
    o_idx = 7'h00;
  end
  // strobe held for exactly the taking edge; index scrambled after so no stale value lingers
  // the leading edge wait keeps two calls from touching the strobe in one time step
  task automatic rd_word(input idfw_idx_t idx, output idfw_word_t w, output logic ok);
    @(posedge i_clk);
    #1;
    o_rd = 1'b1;
    o_idx = idx;
    @(posedge i_clk);
    #1 o_rd = 1'b0;
    o_idx = ~idx;
    ok = 1'b0;
    w = 16'h0000;
    for (int n = 0; n < 4 && ok !== 1'b1; n++) begin
      if (i_vld === 1'b1) begin
        ok = 1'b1;
        w = i_data;
      end else begin
        @(posedge i_clk);
        #1;
      end
    end
  endtask
  // all zeros or all ones means feature words carry nothing
  function automatic logic indicated(input idfw_word_t w);
    return (w !== 16'h0000) && (w !== 16'hffff);
  endfunction
endmodule

// ==== sim/tb_identify_feature_words.sv ====
`timescale 1ns/1ps
// ****************
// bench top
// ****************
module tb_identify_feature_words import idfw_pkg::*;;
  logic       i_mclk, i_sys_rst, i_rd, o_vld, o_pio_vld, ok;
  idfw_cfg_s  cfg;
  idfw_idx_t  idx;
  idfw_word_t o_data, got;
  int         mismatches, n_tests, seed;
  idfw_idx_t  ids [15] = '{7'h43, 7'h44, 7'h52, 7'h53, 7'h54, 7'h55, 7'h56, 7'h57,
                           7'h58, 7'h59, 7'h5a, 7'h5b, 7'h5c, 7'h42, 7'h7f};
  idfw_words u_dut (.I_MCLK(i_mclk), .I_SYS_RST(i_sys_rst), .I_CFG(cfg), .I_RD(i_rd),
    .I_IDX(idx), .O_VLD(o_vld), .O_DATA(o_data), .O_PIO_VLD(o_pio_vld));
  idfw_host u_host (.i_clk(i_mclk), .i_vld(o_vld), .i_data(o_data), .o_rd(i_rd), .o_idx(idx));
  // expected word from settings; unlisted indices read zero
  function automatic idfw_word_t exp_word(input idfw_cfg_s c, input idfw_idx_t i);
    idfw_word_t w;
    w = 16'h0000;
    case (i)
      7'h43: w = (c.pio_m3 | c.pio_m4) ? 16'h00b4 : 16'h0000;
      7'h44: w = c.pio_m4 ? 16'h0078 : (c.pio_m3 ? 16'h00b4 : 16'h0000);
      7'h52: w = 16'h7008 | {9'h000, c.la_sup, c.wc_sup, 3'h0, c.sec_sup, 1'b0};
      7'h53: w = 16'h4004 | {12'h000, c.apm_sup, 3'h0};
      7'h54, 7'h57: w = 16'h4000;
      7'h55: w = 16'h7008 | {9'h000, c.la_en, c.wc_en, 3'h0, c.sec_en, 1'b0};
      7'h56: w = 16'h0004 | {12'h000, c.apm_en, 3'h0};
      7'h58: begin
        for (int m = 0; m < 5; m++) w[m] = c.udma_any && m <= c.udma_max;
        if (c.udma_any && c.udma_sel && !c.mdma_sel) w[8 + c.udma_mode] = 1'b1;
      end
      7'h59: w = {8'h00, c.erase_t};
      7'h5a: w = {8'h00, c.eerase_t};
      7'h5b: w = {8'h00, c.apm_lvl};
      default: w = 16'h0000;
    endcase
    return w;
  endfunction
  task automatic chk(input idfw_word_t g, input idfw_word_t e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic stop_test();
    if (mismatches == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  // corner settings first (all clear, all set but mdma_sel clear and udma fields capped at 4), then random ones
  initial begin
    seed = 32'h0000_18cd;
    mismatches = 0;
    n_tests = 0;
    i_sys_rst = 1'b1;
    cfg = '0;
    repeat (6) @(posedge i_mclk);
    #1 i_sys_rst = 1'b0;
    chk(o_data, 16'h0000);
    for (int k = 0; k < 40; k++) begin
      cfg = (k == 0) ? '0 : (k == 1) ? '1 : idfw_cfg_s'({$random(seed), $random(seed)});
      if (cfg.udma_max > 3'h4) cfg.udma_max = 3'h4;
      if (cfg.udma_mode > cfg.udma_max) cfg.udma_mode = cfg.udma_max;
      if (k == 1) cfg.mdma_sel = 1'b0;
      foreach (ids[j]) begin
        u_host.rd_word(ids[j], got, ok);
        if (ok !== 1'b1) begin
          mismatches++;
          stop_test();
        end
        chk(got, exp_word(cfg, ids[j]));
        if (ids[j] inside {[7'h52 : 7'h57]}) chk({15'h0000, u_host.indicated(got)}, 16'h0001);
      end
      chk({15'h0000, o_pio_vld}, {15'h0000, cfg.pio_m3 | cfg.pio_m4});
    end
    stop_test();
  end
endmodule
